// file: hdl/seq_step_consts.svh
`ifndef SEQ_STEP_CONSTS_SVH
`define SEQ_STEP_CONSTS_SVH

// register indices; the byte address on the bus is four times the index
`define STEP_SIX_INDEX     8'h96
`define STEP_SEVEN_INDEX   8'h97
`define INDEX_LSB          2
`define INDEX_MSB          9

// reset values
`define STEP_SIX_RESET     16'h0006
`define STEP_SEVEN_RESET   16'h0007

// field layout of a step register
`define ENABLE_BIT         15
`define GAIN_MSB           14
`define GAIN_LSB           13
`define RESERVED_MSB       12
`define RESERVED_LSB       5
`define NEGATIVE_BIT       4
`define POSITIVE_MSB       3
`define POSITIVE_LSB       0

// writable bits: 15, 14:13, 4, 3:0
`define WRITE_MASK         16'hE01F
`define UPPER_PAD          16'h0000
`define READ_UNMAPPED      32'h0000_0000

// gain codes and the factors they give
`define GAIN_CODE_ONE      2'h0
`define GAIN_CODE_TWO      2'h1
`define GAIN_FACTOR_ONE    3'h1
`define GAIN_FACTOR_TWO    3'h2
`define GAIN_FACTOR_FOUR   3'h4

`endif

// file: hdl/seq_step_pkg.sv
package seq_step_pkg;

	// one step register as software sees it
	typedef struct packed {
		logic       enable;
		logic [1:0] gain;
		logic [7:0] reserved;
		logic       negative;
		logic [3:0] positive;
	} step_cfg_type;

	typedef enum logic [1:0] {
		NEG_GROUND,
		NEG_EXT_SEVEN,
		NEG_AUTO
	} neg_source_type;

	// what the converter front end is told for one step
	typedef struct packed {
		logic           enable;
		logic [2:0]     gain_factor;
		neg_source_type negative;
		logic           internal;
		logic [3:0]     positive;
	} step_route_type;

	typedef enum {
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_type;

endpackage : seq_step_pkg

// file: hdl/step_route_decode.sv
`timescale 1ns/1ps
`include "seq_step_consts.svh"

module step_route_decode (
	input  wire seq_step_pkg::step_cfg_type   i_cfg,
	output seq_step_pkg::step_route_type      o_route
);
	import seq_step_pkg::*;

	always_comb begin
		o_route.enable   = i_cfg.enable;
		o_route.positive = i_cfg.positive;
		// top half of the positive code selects an internal source
		o_route.internal = i_cfg.positive[`POSITIVE_MSB];
		unique case (i_cfg.gain)
			`GAIN_CODE_ONE: o_route.gain_factor = `GAIN_FACTOR_ONE;
			`GAIN_CODE_TWO: o_route.gain_factor = `GAIN_FACTOR_TWO;
			default:        o_route.gain_factor = `GAIN_FACTOR_FOUR;
		endcase
		// internal sources pick their own return path
		if (i_cfg.positive[`POSITIVE_MSB]) begin
			o_route.negative = NEG_AUTO;
		end else if (i_cfg.negative) begin
			o_route.negative = NEG_EXT_SEVEN;
		end else begin
			o_route.negative = NEG_GROUND;
		end
	end

endmodule : step_route_decode

// file: hdl/seq_step_config_register.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "seq_step_consts.svh"

module seq_step_config_register (
	input  wire logic                         i_mclk,
	input  wire logic                         i_rst,
	input  wire logic [9:0]                   i_avs_address,
	input  wire logic                         i_avs_read,
	input  wire logic                         i_avs_write,
	input  wire logic [31:0]                  i_avs_writedata,
	input  wire logic [3:0]                   i_avs_byteenable,
	output logic [31:0]                       o_avs_readdata,
	output logic                              o_avs_waitrequest,
	output seq_step_pkg::step_route_type      o_step_route [2]
);
	import seq_step_pkg::*;

	localparam int STEPS = 2;

	bus_state_type  state_reg;
	bus_state_type  state_next;
	logic           waitrequest_reg;
	logic           waitrequest_next;
	logic [31:0]    readdata_reg;
	logic [31:0]    readdata_next;

	logic [15:0]    cfg_reg   [STEPS];
	logic [15:0]    cfg_next  [STEPS];
	logic [7:0]     step_index [STEPS];
	logic [STEPS-1:0] hit;
	step_route_type route_comb [STEPS];
	step_route_type route_reg  [STEPS];

	logic           request;
	logic           commit_write;
	logic [7:0]     req_index;
	logic [31:0]    read_word;

	assign step_index[0] = `STEP_SIX_INDEX;
	assign step_index[1] = `STEP_SEVEN_INDEX;

	assign request   = i_avs_read | i_avs_write;
	assign req_index = i_avs_address[`INDEX_MSB:`INDEX_LSB];
	// the write lands on the one edge where waitrequest is seen low
	assign commit_write = (state_reg == BUS_ANSWER) & i_avs_write;

	// ---------------------------------------------------------------
	// bus handshake: every access waits one cycle, then answers
	// ---------------------------------------------------------------
	always_comb begin
		state_next       = state_reg;
		waitrequest_next = 1'b1;
		readdata_next    = readdata_reg;
		unique case (state_reg)
			BUS_IDLE: begin
				if (request) begin
					state_next       = BUS_ANSWER;
					waitrequest_next = 1'b0;
					readdata_next    = read_word;
				end
			end
			BUS_ANSWER: begin
				// back to idle so a held request is never taken twice
				state_next = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_reg       <= BUS_IDLE;
			waitrequest_reg <= 1'b1;
			readdata_reg    <= `READ_UNMAPPED;
		end else begin
			state_reg       <= state_next;
			waitrequest_reg <= waitrequest_next;
			readdata_reg    <= readdata_next;
		end
	end

	// read mux; an unmapped index reads zero
	always_comb begin
		read_word = `READ_UNMAPPED;
		for (int s = 0; s < STEPS; s++) begin
			if (hit[s]) begin
				// reserved bits are never stored, so they read zero
				read_word = {`UPPER_PAD, cfg_reg[s] & `WRITE_MASK};
			end
		end
	end

	// ---------------------------------------------------------------
	// one step register and its decoder per entry
	// ---------------------------------------------------------------
	for (genvar g = 0; g < STEPS; g++) begin : gen_step
		logic [15:0] merged;

		assign hit[g] = (req_index == step_index[g]);

		always_comb begin
			merged[15:8] = i_avs_byteenable[1] ? i_avs_writedata[15:8]
			                                   : cfg_reg[g][15:8];
			merged[7:0]  = i_avs_byteenable[0] ? i_avs_writedata[7:0]
			                                   : cfg_reg[g][7:0];
			cfg_next[g] = cfg_reg[g];
			if (commit_write && hit[g]) begin
				// upper lanes and reserved bits are dropped here
				cfg_next[g] = merged & `WRITE_MASK;
			end
		end

		step_route_decode step_route_decode_i (
			.i_cfg   (step_cfg_type'(cfg_reg[g])),
			.o_route (route_comb[g])
		);
	end

	// reset values differ per step, so they are named one by one
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cfg_reg[0] <= `STEP_SIX_RESET;
			cfg_reg[1] <= `STEP_SEVEN_RESET;
		end else begin
			cfg_reg[0] <= cfg_next[0];
			cfg_reg[1] <= cfg_next[1];
		end
	end

	// routes are registered so the analog side sees clean levels
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			for (int s = 0; s < STEPS; s++) begin
				route_reg[s] <= '0;
			end
		end else begin
			for (int s = 0; s < STEPS; s++) begin
				route_reg[s] <= route_comb[s];
			end
		end
	end

	assign o_avs_waitrequest = waitrequest_reg;
	assign o_avs_readdata    = readdata_reg;
	assign o_step_route      = route_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	logic [15:0] six_q;
	logic [15:0] seven_q;
	step_cfg_type six_cfg;
	step_cfg_type seven_cfg;
	assign six_q   = cfg_reg[0];
	assign seven_q = cfg_reg[1];
	assign six_cfg = step_cfg_type'(cfg_reg[0]);
	assign seven_cfg = step_cfg_type'(cfg_reg[1]);

	sequence req_taken;
		state_reg == BUS_IDLE && request;
	endsequence

	sequence answer_pulse;
		!o_avs_waitrequest ##1 o_avs_waitrequest;
	endsequence

	sequence six_full_write;
		commit_write && hit[0] && i_avs_byteenable[1:0] == 2'h3;
	endsequence

	sequence six_read_taken;
		req_taken ##0 (i_avs_read && req_index == `STEP_SIX_INDEX);
	endsequence

	sequence seven_read_taken;
		req_taken ##0 (i_avs_read && req_index == `STEP_SEVEN_INDEX);
	endsequence

	sequence unmapped_read_taken;
		req_taken ##0 (i_avs_read && hit == '0);
	endsequence

	answer_timing_a: assert property (
		req_taken |=> answer_pulse)
		else $error("bus answer not one cycle after request");

	six_write_a: assert property (
		six_full_write |=>
			six_q == ($past(i_avs_writedata[15:0]) & `WRITE_MASK))
		else $error("step six write not stored as masked word");

	six_read_a: assert property (
		six_read_taken |=>
			o_avs_readdata == {`UPPER_PAD, $past(six_q)} && !o_avs_waitrequest)
		else $error("step six read data wrong");

	seven_read_a: assert property (
		seven_read_taken |=>
			o_avs_readdata == {`UPPER_PAD, $past(seven_q)})
		else $error("step seven read data wrong");

	reserved_zero_a: assert property (
		!o_avs_waitrequest |->
			o_avs_readdata[`RESERVED_MSB:`RESERVED_LSB] == 8'h00
			&& o_avs_readdata[31:16] == `UPPER_PAD)
		else $error("reserved bits read nonzero");

	stored_reserved_a: assert property (
		six_q[`RESERVED_MSB:`RESERVED_LSB] == 8'h00
		&& seven_q[`RESERVED_MSB:`RESERVED_LSB] == 8'h00)
		else $error("reserved bits stored");

	// routes keep their reset zeros through the edge that releases reset,
	// so decode checks only start from an edge where reset was seen low
	enable_follow_a: assert property (
		!i_rst |=> o_step_route[0].enable == $past(six_q[`ENABLE_BIT]))
		else $error("step six enable not routed");

	gain_four_a: assert property (
		!i_rst && six_cfg.gain[1] |=>
			o_step_route[0].gain_factor == `GAIN_FACTOR_FOUR)
		else $error("gain code 1x not factor four");

	gain_low_a: assert property (
		!i_rst && !six_cfg.gain[1] |=>
			o_step_route[0].gain_factor ==
			($past(six_cfg.gain[0]) ? `GAIN_FACTOR_TWO : `GAIN_FACTOR_ONE))
		else $error("gain code 0x wrong factor");

	neg_select_a: assert property (
		!i_rst && !six_cfg.positive[`POSITIVE_MSB] |=>
			o_step_route[0].negative ==
			($past(six_cfg.negative) ? NEG_EXT_SEVEN : NEG_GROUND))
		else $error("negative input select wrong");

	pos_external_a: assert property (
		!i_rst && !six_cfg.positive[`POSITIVE_MSB] |=>
			!o_step_route[0].internal
			&& o_step_route[0].positive == $past(six_cfg.positive))
		else $error("external positive input not routed");

	pos_internal_a: assert property (
		!i_rst && six_cfg.positive[`POSITIVE_MSB] |=>
			o_step_route[0].internal
			&& o_step_route[0].positive == $past(six_cfg.positive))
		else $error("internal source not routed");

	auto_negative_a: assert property (
		!i_rst && six_cfg.positive[`POSITIVE_MSB] |=>
			o_step_route[0].negative == NEG_AUTO)
		else $error("internal source did not force auto negative");

	write_hold_a: assert property (
		!commit_write |=> six_q == $past(six_q) && seven_q == $past(seven_q))
		else $error("register changed without a write");

	unmapped_read_a: assert property (
		unmapped_read_taken |=> o_avs_readdata == `READ_UNMAPPED)
		else $error("unmapped index did not read zero");

	lane_keep_a: assert property (
		commit_write && hit[0] && !i_avs_byteenable[1] |=>
			six_q[`ENABLE_BIT:`GAIN_LSB] ==
			$past(six_q[`ENABLE_BIT:`GAIN_LSB]))
		else $error("disabled upper lane changed step six");

	reset_value_a: assert property (
		$past(i_rst) && !i_rst |->
			six_q == `STEP_SIX_RESET && seven_q == `STEP_SEVEN_RESET)
		else $error("step registers not at reset values");

	seven_enable_a: assert property (
		!i_rst |=> o_step_route[1].enable == $past(seven_cfg.enable))
		else $error("step seven enable not routed");

	seven_gain_a: assert property (
		!i_rst |=>
			o_step_route[1].gain_factor == ($past(seven_cfg.gain[1])
			? `GAIN_FACTOR_FOUR : $past(seven_cfg.gain[0])
			? `GAIN_FACTOR_TWO : `GAIN_FACTOR_ONE))
		else $error("step seven gain factor wrong");

	seven_ext_neg_a: assert property (
		!i_rst && !seven_cfg.positive[`POSITIVE_MSB] |=>
			o_step_route[1].negative ==
			($past(seven_cfg.negative) ? NEG_EXT_SEVEN : NEG_GROUND))
		else $error("step seven negative input select wrong");

	seven_auto_a: assert property (
		!i_rst && seven_cfg.positive[`POSITIVE_MSB] |=>
			o_step_route[1].negative == NEG_AUTO)
		else $error("step seven internal source not auto negative");

	seven_positive_a: assert property (
		!i_rst |=>
			o_step_route[1].positive == $past(seven_cfg.positive)
			&& o_step_route[1].internal ==
			$past(seven_cfg.positive[`POSITIVE_MSB]))
		else $error("step seven positive input not routed");

endmodule : seq_step_config_register

// file: bench/seq_step_config_register_tb_top.sv
`timescale 1ns/1ps
module seq_step_config_register_tb_top;
	import seq_step_pkg::*;

	localparam logic [9:0] six_a = 10'h258;
	localparam logic [9:0] sev_a = 10'h25C;
	localparam logic [15:0] msk = 16'hE01F;

	logic           i_mclk;
	logic           i_rst;
	logic [9:0]     i_avs_address;
	logic           i_avs_read;
	logic           i_avs_write;
	logic [31:0]    i_avs_writedata;
	logic [3:0]     i_avs_byteenable;
	logic [31:0]    o_avs_readdata;
	logic           o_avs_waitrequest;
	step_route_type o_step_route [2];
	int             failures = 0;
	int             n_compared = 0;

	seq_step_config_register seq_step_config_register_i (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.o_step_route(o_step_route)
	);

	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	task automatic tally_and_finish;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	function automatic step_route_type exp_route(input logic [15:0] c);
		step_route_type r;
		r.enable = c[15];
		case (c[14:13])
			2'h0: r.gain_factor = 3'h1;
			2'h1: r.gain_factor = 3'h2;
			default: r.gain_factor = 3'h4;
		endcase
		r.internal = c[3];
		// an internal source overrides the stored negative bit
		r.negative = c[3] ? NEG_AUTO : (c[4] ? NEG_EXT_SEVEN : NEG_GROUND);
		r.positive = c[3:0];
		return r;
	endfunction : exp_route

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t read %h exp %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_route(input int idx, input logic [15:0] cfg);
		step_route_type e;
		e = exp_route(cfg);
		n_compared++;
		if (o_step_route[idx] !== e) begin
			failures++;
			$display("[FAIL] %0t route%0d %h exp %h", $time, idx,
				o_step_route[idx], e);
		end
	endtask : chk_route

	// request held until waitrequest is sampled low; one idle edge after
	task automatic bus(input logic [9:0] a, input logic wr,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		i_avs_write <= wr;
		i_avs_read <= ~wr;
		// no cycle limit here: a slave that never answers is the watchdog's
		do begin
			@(posedge i_mclk);
		end while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		@(posedge i_mclk);
	endtask : bus

	task automatic wr16(input logic [9:0] a, input logic [15:0] d,
		input logic [3:0] be);
		logic [31:0] q;
		// upper half carries junk that must be dropped
		bus(a, 1'b1, {16'hA5C3, d}, be, q);
	endtask : wr16

	task automatic rd(input logic [9:0] a, input logic [15:0] exp);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0000_0000, 4'hF, q);
		chk_word(q, {16'h0000, exp});
	endtask : rd

	task automatic test_reset_values;
		rd(six_a, 16'h0006);
		rd(sev_a, 16'h0007);
		chk_route(0, 16'h0006);
		chk_route(1, 16'h0007);
	endtask : test_reset_values

	task automatic test_all_codes;
		logic [15:0] v;
		for (int i = 0; i < 16; i++) begin
			v = {i[0], i[1:0], 8'hFF, ~i[0], i[3:0]};
			wr16(six_a, v, 4'hF);
			wr16(sev_a, ~v, 4'hF);
			rd(six_a, v & msk);
			rd(sev_a, ~v & msk);
			chk_route(0, v);
			chk_route(1, ~v);
		end
	endtask : test_all_codes

	task automatic test_lanes;
		wr16(six_a, 16'h0000, 4'hF);
		wr16(six_a, 16'hFFFF, 4'h1);
		rd(six_a, 16'h001F);
		wr16(six_a, 16'hFFFF, 4'h2);
		rd(six_a, 16'hE01F);
		wr16(six_a, 16'h0000, 4'hC);
		rd(six_a, 16'hE01F);
	endtask : test_lanes

	task automatic test_unmapped;
		wr16(sev_a, 16'h0000, 4'hF);
		wr16(10'h260, 16'hFFFF, 4'hF);
		wr16(10'h254, 16'h0000, 4'hF);
		rd(10'h260, 16'h0000);
		rd(10'h254, 16'h0000);
		rd(six_a, 16'hE01F);
		rd(sev_a, 16'h0000);
	endtask : test_unmapped

	task automatic test_mid_reset;
		i_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_mclk);
		test_reset_values();
	endtask : test_mid_reset

	// the scenarios need about 300 clocks; 2000 leaves ample margin
	initial begin
		#20000;
		failures++;
		$display("[FAIL] %0t watchdog", $time);
		tally_and_finish();
	end

	initial begin
		i_rst = 1'b1;
		i_avs_address = 10'h000;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0000_0000;
		i_avs_byteenable = 4'h0;
		repeat (5) @(posedge i_mclk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_mclk);
		test_reset_values();
		test_all_codes();
		test_lanes();
		test_unmapped();
		test_mid_reset();
		tally_and_finish();
	end
endmodule : seq_step_config_register_tb_top
